// file: include/iowd_defs.svh
// Register indexes, field positions and reset values of the I/O windows
`ifndef IOWD_DEFS_SVH
`define IOWD_DEFS_SVH
// ==========================================
// Register indexes (byte address = index * 4)
`define IOWD_IDX_MAPEN 6'h06
`define IOWD_IDX_CTRL 6'h07
`define IOWD_IDX_W0_START_LO 6'h08
`define IOWD_IDX_W0_START_HI 6'h09
`define IOWD_IDX_W0_END_LO 6'h0A
`define IOWD_IDX_W0_END_HI 6'h0B
`define IOWD_IDX_W1_START_LO 6'h0C
`define IOWD_IDX_W1_START_HI 6'h0D
`define IOWD_IDX_W1_END_LO 6'h0E
`define IOWD_IDX_W1_END_HI 6'h0F
`define IOWD_IDX_W0_OFS_LO 6'h36
`define IOWD_IDX_W0_OFS_HI 6'h37
`define IOWD_IDX_W1_OFS_LO 6'h38
`define IOWD_IDX_W1_OFS_HI 6'h39
// ==========================================
// Field positions
`define IOWD_CTRL_SIZE0 0
`define IOWD_CTRL_AUTO0 1
`define IOWD_CTRL_TSEL0 3
`define IOWD_CTRL_SIZE1 4
`define IOWD_CTRL_AUTO1 5
`define IOWD_CTRL_TSEL1 7
`define IOWD_CTRL_COMPAT0 2
`define IOWD_CTRL_COMPAT1 6
`define IOWD_MAPEN_W0 6
`define IOWD_MAPEN_W1 7
// ==========================================
// Reset values
`define IOWD_RST_BYTE 8'h00
`define IOWD_RST_WORD 16'h0000
`define IOWD_RST_RDATA 32'h0000_0000
`endif

// file: include/iowd_pkg.sv
// Types shared by the I/O window decode block
package iowd_pkg;
  typedef logic [15:0] iowd_addr_t;
  typedef enum logic
  {
    IOWD_WIN0 = 1'b0,
    IOWD_WIN1 = 1'b1
  } iowd_win_e;
  typedef enum logic
  {
    IOWD_TIMER_SET0 = 1'b0,
    IOWD_TIMER_SET1 = 1'b1
  } iowd_timer_e;
endpackage

// file: src/iowd_top.sv
// I/O window control registers and host I/O start/end decode
//
// The implementer's own choice: register access over APB.
`include "iowd_defs.svh"

module iowd_top
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_io_req,
  input wire iowd_pkg::iowd_addr_t i_io_addr,
  input wire logic i_card_io_width16_indicator_n,
  output logic o_card_cycle_start,
  output iowd_pkg::iowd_win_e o_io_window,
  output iowd_pkg::iowd_addr_t o_card_addr,
  output logic o_width16,
  output iowd_pkg::iowd_timer_e o_timer_set
);
  import iowd_pkg::*;

  // ==========================================
  // Register state
  logic [7:0] ctrl;
  logic [1:0] map_en;
  iowd_addr_t win_start [2];
  iowd_addr_t win_end [2];
  iowd_addr_t win_ofs [2];
  logic [31:0] next_rdata;
  logic next_err;
  logic [5:0] idx;
  logic wr_en;
  logic hit0;
  logic hit1;

  // Inclusive range check shared by both windows
  function automatic logic in_win(iowd_addr_t a, iowd_addr_t s,
    iowd_addr_t e);
    in_win = (a >= s) && (a <= e);
  endfunction

  // Width choice: auto sizing overrides the stored size bit
  function automatic logic pick_width(logic auto_sz, logic size,
    logic ind_n);
    pick_width = auto_sz ? ~ind_n : size;
  endfunction

  // ==========================================
  // APB decode
  assign idx = i_paddr[7:2];
  // Write lands only at the access edge where ready is seen high
  assign wr_en = i_psel & i_penable & i_pwrite & o_pready;

  // Zero-wait slave: ready in the cycle after setup
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_pready <= 1'b0;
    else
      o_pready <= i_psel & ~i_penable;
  end

  // Read data and error are latched during the setup cycle
  always_comb
  begin
    next_rdata = `IOWD_RST_RDATA;
    next_err = 1'b0;
    if (i_paddr[1:0] != 2'h0)
      next_err = 1'b1;
    else if (idx == `IOWD_IDX_MAPEN)
      next_rdata[7:0] = {map_en, 6'h00};
    else if (idx == `IOWD_IDX_CTRL)
      next_rdata[7:0] = ctrl;
    else if (idx == `IOWD_IDX_W0_START_LO)
      next_rdata[7:0] = win_start[0][7:0];
    else if (idx == `IOWD_IDX_W0_START_HI)
      next_rdata[7:0] = win_start[0][15:8];
    else if (idx == `IOWD_IDX_W0_END_LO)
      next_rdata[7:0] = win_end[0][7:0];
    else if (idx == `IOWD_IDX_W0_END_HI)
      next_rdata[7:0] = win_end[0][15:8];
    else if (idx == `IOWD_IDX_W1_START_LO)
      next_rdata[7:0] = win_start[1][7:0];
    else if (idx == `IOWD_IDX_W1_START_HI)
      next_rdata[7:0] = win_start[1][15:8];
    else if (idx == `IOWD_IDX_W1_END_LO)
      next_rdata[7:0] = win_end[1][7:0];
    else if (idx == `IOWD_IDX_W1_END_HI)
      next_rdata[7:0] = win_end[1][15:8];
    else if (idx == `IOWD_IDX_W0_OFS_LO)
      next_rdata[7:0] = win_ofs[0][7:0];
    else if (idx == `IOWD_IDX_W0_OFS_HI)
      next_rdata[7:0] = win_ofs[0][15:8];
    else if (idx == `IOWD_IDX_W1_OFS_LO)
      next_rdata[7:0] = win_ofs[1][7:0];
    else if (idx == `IOWD_IDX_W1_OFS_HI)
      next_rdata[7:0] = win_ofs[1][15:8];
    else
      next_err = 1'b1; // Unmapped index answers with an error
  end

  // Answer registers; cleared outside a transfer
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_prdata <= `IOWD_RST_RDATA;
      o_pslverr <= 1'b0;
    end
    else if (i_psel & ~i_penable)
    begin
      o_prdata <= i_pwrite ? `IOWD_RST_RDATA : next_rdata;
      o_pslverr <= next_err;
    end
    else
    begin
      o_prdata <= `IOWD_RST_RDATA;
      o_pslverr <= 1'b0;
    end
  end

  // ==========================================
  // Control and enable registers
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ctrl <= `IOWD_RST_BYTE;
      map_en <= 2'h0;
    end
    else if (wr_en && !o_pslverr)
    begin
      if (idx == `IOWD_IDX_CTRL)
        ctrl <= i_pwdata[7:0];
      else if (idx == `IOWD_IDX_MAPEN)
        map_en <= i_pwdata[`IOWD_MAPEN_W1:`IOWD_MAPEN_W0];
    end
  end

  // Address bytes; each byte lands in its half of the word
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      win_start[0] <= `IOWD_RST_WORD;
      win_start[1] <= `IOWD_RST_WORD;
      win_end[0] <= `IOWD_RST_WORD;
      win_end[1] <= `IOWD_RST_WORD;
      win_ofs[0] <= `IOWD_RST_WORD;
      win_ofs[1] <= `IOWD_RST_WORD;
    end
    else if (wr_en && !o_pslverr)
    begin
      if (idx == `IOWD_IDX_W0_START_LO)
        win_start[0][7:0] <= i_pwdata[7:0];
      else if (idx == `IOWD_IDX_W0_START_HI)
        win_start[0][15:8] <= i_pwdata[7:0];
      else if (idx == `IOWD_IDX_W1_START_LO)
        win_start[1][7:0] <= i_pwdata[7:0];
      else if (idx == `IOWD_IDX_W1_START_HI)
        win_start[1][15:8] <= i_pwdata[7:0];
      else if (idx == `IOWD_IDX_W0_END_LO)
        win_end[0][7:0] <= i_pwdata[7:0];
      else if (idx == `IOWD_IDX_W0_END_HI)
        win_end[0][15:8] <= i_pwdata[7:0];
      else if (idx == `IOWD_IDX_W1_END_LO)
        win_end[1][7:0] <= i_pwdata[7:0];
      else if (idx == `IOWD_IDX_W1_END_HI)
        win_end[1][15:8] <= i_pwdata[7:0];
      else if (idx == `IOWD_IDX_W0_OFS_LO)
        win_ofs[0][7:0] <= i_pwdata[7:0];
      else if (idx == `IOWD_IDX_W0_OFS_HI)
        win_ofs[0][15:8] <= i_pwdata[7:0];
      else if (idx == `IOWD_IDX_W1_OFS_LO)
        win_ofs[1][7:0] <= i_pwdata[7:0];
      else if (idx == `IOWD_IDX_W1_OFS_HI)
        win_ofs[1][15:8] <= i_pwdata[7:0];
    end
  end

  // ==========================================
  // Host I/O decode; window 0 wins if software lets them overlap
  assign hit0 = map_en[0] &&
    in_win(i_io_addr, win_start[0], win_end[0]);
  assign hit1 = map_en[1] &&
    in_win(i_io_addr, win_start[1], win_end[1]);

  // Start strobe only for a claimed access
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_card_cycle_start <= 1'b0;
    else
      o_card_cycle_start <= i_io_req & (hit0 | hit1);
  end

  // Window attributes held until the next claimed access
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_io_window <= IOWD_WIN0;
      o_card_addr <= `IOWD_RST_WORD;
      o_width16 <= 1'b0;
      o_timer_set <= IOWD_TIMER_SET0;
    end
    else if (i_io_req && hit0)
    begin
      o_io_window <= IOWD_WIN0;
      o_card_addr <= 16'(i_io_addr + win_ofs[0]);
      o_width16 <= pick_width(ctrl[`IOWD_CTRL_AUTO0],
        ctrl[`IOWD_CTRL_SIZE0], i_card_io_width16_indicator_n);
      o_timer_set <= iowd_timer_e'(ctrl[`IOWD_CTRL_TSEL0]);
    end
    else if (i_io_req && hit1)
    begin
      o_io_window <= IOWD_WIN1;
      o_card_addr <= 16'(i_io_addr + win_ofs[1]);
      o_width16 <= pick_width(ctrl[`IOWD_CTRL_AUTO1],
        ctrl[`IOWD_CTRL_SIZE1], i_card_io_width16_indicator_n);
      o_timer_set <= iowd_timer_e'(ctrl[`IOWD_CTRL_TSEL1]);
    end
  end

  // ==========================================
  // Assertions
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  a_w0_manual_size: assert property (
    i_io_req && hit0 && !ctrl[`IOWD_CTRL_AUTO0]
    |=> o_width16 == $past(ctrl[`IOWD_CTRL_SIZE0]))
    else $error("window 0 manual width wrong");

  a_w0_auto_size: assert property (
    i_io_req && hit0 && ctrl[`IOWD_CTRL_AUTO0]
    |=> o_width16 == !$past(i_card_io_width16_indicator_n))
    else $error("window 0 auto width wrong");

  a_w0_timer_pick: assert property (
    i_io_req && hit0
    |=> o_timer_set == iowd_timer_e'($past(ctrl[`IOWD_CTRL_TSEL0])))
    else $error("window 0 timer set wrong");

  a_w1_manual_size: assert property (
    i_io_req && !hit0 && hit1 && !ctrl[`IOWD_CTRL_AUTO1]
    |=> o_width16 == $past(ctrl[`IOWD_CTRL_SIZE1]))
    else $error("window 1 manual width wrong");

  a_w1_auto_size: assert property (
    i_io_req && !hit0 && hit1 && ctrl[`IOWD_CTRL_AUTO1]
    |=> o_width16 == !$past(i_card_io_width16_indicator_n))
    else $error("window 1 auto width wrong");

  a_w1_timer_pick: assert property (
    i_io_req && !hit0 && hit1
    |=> o_timer_set == iowd_timer_e'($past(ctrl[`IOWD_CTRL_TSEL1]))
      && o_io_window == IOWD_WIN1)
    else $error("window 1 timer set wrong");

  a_range_claim: assert property (
    i_io_req && map_en[0] && i_io_addr >= win_start[0]
      && i_io_addr <= win_end[0] |=> o_card_cycle_start)
    else $error("in-range access not claimed");

  a_start_bytes: assert property (
    wr_en && !o_pslverr && idx == `IOWD_IDX_W1_START_HI
    |=> win_start[1][15:8] == $past(i_pwdata[7:0])
      && $stable(win_start[1][7:0]))
    else $error("start high byte not assembled");

  a_start_readback: assert property (
    i_psel && !i_penable && !i_pwrite
      && i_paddr == {`IOWD_IDX_W0_START_LO, 2'h0}
    |=> o_pready && o_prdata[7:0] == $past(win_start[0][7:0]))
    else $error("start low readback wrong");

  a_enable_gate: assert property (
    i_io_req && !map_en[0] && !map_en[1] |=> !o_card_cycle_start)
    else $error("disabled window claimed");

  a_end_bound: assert property (
    i_io_req && i_io_addr > win_end[0] && i_io_addr > win_end[1]
    |=> !o_card_cycle_start)
    else $error("access above end claimed");

  a_offset_add: assert property (
    i_io_req && hit0
    |=> o_card_addr == 16'($past(i_io_addr) + $past(win_ofs[0])))
    else $error("card address offset wrong");

  a_no_hit_idle: assert property (
    !(i_io_req && (hit0 || hit1)) |=> !o_card_cycle_start)
    else $error("card cycle without hit");

  a_compat_bits: assert property (
    wr_en && !o_pslverr && idx == `IOWD_IDX_CTRL
    |=> ctrl[`IOWD_CTRL_COMPAT0] == $past(i_pwdata[`IOWD_CTRL_COMPAT0])
      && ctrl[`IOWD_CTRL_COMPAT1] == $past(i_pwdata[`IOWD_CTRL_COMPAT1]))
    else $error("compatibility bits not kept");

  c_w0_claim: cover property (i_io_req && hit0 ##1 o_card_cycle_start);
  c_w1_auto: cover property (i_io_req && !hit0 && hit1
    && ctrl[`IOWD_CTRL_AUTO1]);
  c_miss: cover property (i_io_req && !hit0 && !hit1);
  c_bad_idx: cover property (o_pready && o_pslverr);
endmodule

// file: testbench/iowd_card_model.sv
// Behavioural PC card model facing the I/O window decode block
module iowd_card_model
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_wide,
  input wire logic i_cycle_start,
  output logic o_width16_indicator_n,
  output logic [7:0] o_cycles
);
  timeunit 1ns;
  timeprecision 1ps;
  // Indicator is active low; the bench picks the port width per access
  assign o_width16_indicator_n = ~i_wide;
  // Counts card cycles so that unclaimed accesses can be seen staying quiet
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_cycles <= 8'h00;
    else if (i_cycle_start)
      o_cycles <= o_cycles + 8'h01;
  end
endmodule

// file: testbench/testbench.sv
// Self-checking bench for the I/O window control and start decode block
`include "iowd_defs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import iowd_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic io_req = 1'b0;
  iowd_addr_t io_addr = 16'h0000;
  logic card_wide = 1'b0;
  logic ind_n;
  logic cyc_start;
  iowd_win_e io_win;
  iowd_addr_t card_addr;
  logic width16;
  iowd_timer_e tset;
  logic [7:0] cycles;
  int n_fail = 0;
  int checked = 0;

  // 100 MHz clock
  always #5 i_clk = ~i_clk;

  iowd_top u_iowd_top (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_io_req(io_req), .i_io_addr(io_addr),
    .i_card_io_width16_indicator_n(ind_n), .o_card_cycle_start(cyc_start),
    .o_io_window(io_win), .o_card_addr(card_addr), .o_width16(width16),
    .o_timer_set(tset));

  iowd_card_model u_iowd_card_model (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_wide(card_wide), .i_cycle_start(cyc_start),
    .o_width16_indicator_n(ind_n), .o_cycles(cycles));

  // ==========================================
  // Shared tasks
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, exp, input string m);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
    output logic [31:0] r, output logic e);
    int n;
    @(posedge i_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge i_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge i_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 8);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      n_fail++;
      $display("[ERR] %0t no bus answer", $time);
      conclude();
    end
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, {idx, 2'b00}, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 8'h00, r, e);
    cmp(r, {24'h000000, x}, "read data");
    cmp({31'h0, e}, {31'h0, xe}, "slave error");
  endtask

  // One host access; the claim shows one cycle after the request edge
  task automatic io(input iowd_addr_t a, input logic hit, input logic w,
    input iowd_addr_t ca, input logic w16, input logic ts);
    @(posedge i_clk);
    io_req <= 1'b1;
    io_addr <= a;
    @(posedge i_clk);
    io_req <= 1'b0;
    #1;
    cmp({31'h0, cyc_start}, {31'h0, hit}, "claim");
    if (hit)
    begin
      cmp({31'h0, io_win}, {31'h0, w}, "window");
      cmp({16'h0, card_addr}, {16'h0, ca}, "card address");
      cmp({31'h0, width16}, {31'h0, w16}, "width");
      cmp({31'h0, tset}, {31'h0, ts}, "timer set");
    end
  endtask

  // ==========================================
  // Scenarios
  task automatic t_reset();
    rd({`IOWD_IDX_CTRL, 2'b00}, 8'h00, 1'b0);
    rd({`IOWD_IDX_W0_START_LO, 2'b00}, 8'h00, 1'b0);
    rd({`IOWD_IDX_W0_START_HI, 2'b00}, 8'h00, 1'b0);
    rd({`IOWD_IDX_W1_START_LO, 2'b00}, 8'h00, 1'b0);
    rd({`IOWD_IDX_W1_START_HI, 2'b00}, 8'h00, 1'b0);
    rd(8'hFC, 8'h00, 1'b1);
    rd(8'h1D, 8'h00, 1'b1);
    $display("test reset done");
  endtask

  // Windows kept well clear of any base address range
  task automatic t_regs();
    wr(`IOWD_IDX_CTRL, 8'h44);
    rd({`IOWD_IDX_CTRL, 2'b00}, 8'h44, 1'b0);
    wr(`IOWD_IDX_W0_START_LO, 8'h10);
    wr(`IOWD_IDX_W0_START_HI, 8'h01);
    wr(`IOWD_IDX_W1_START_LO, 8'h00);
    wr(`IOWD_IDX_W1_START_HI, 8'h03);
    rd({`IOWD_IDX_W0_START_LO, 2'b00}, 8'h10, 1'b0);
    rd({`IOWD_IDX_W1_START_HI, 2'b00}, 8'h03, 1'b0);
    wr(`IOWD_IDX_W0_END_LO, 8'hFF);
    wr(`IOWD_IDX_W0_END_HI, 8'h01);
    wr(`IOWD_IDX_W1_END_LO, 8'hFF);
    wr(`IOWD_IDX_W1_END_HI, 8'h03);
    wr(`IOWD_IDX_W0_OFS_HI, 8'h10);
    wr(`IOWD_IDX_W1_OFS_LO, 8'h20);
    $display("test registers done");
  endtask

  task automatic t_window();
    wr(`IOWD_IDX_CTRL, 8'h00);
    io(16'h0110, 1'b0, 1'b0, 16'h0, 1'b0, 1'b0);
    wr(`IOWD_IDX_MAPEN, 8'hC0);
    rd({`IOWD_IDX_MAPEN, 2'b00}, 8'hC0, 1'b0);
    io(16'h010F, 1'b0, 1'b0, 16'h0, 1'b0, 1'b0);
    io(16'h0110, 1'b1, 1'b0, 16'h1110, 1'b0, 1'b0);
    io(16'h01FF, 1'b1, 1'b0, 16'h11FF, 1'b0, 1'b0);
    io(16'h0200, 1'b0, 1'b0, 16'h0, 1'b0, 1'b0);
    cmp({16'h0, card_addr}, 32'h11FF, "held address");
    io(16'h0300, 1'b1, 1'b1, 16'h0320, 1'b0, 1'b0);
    // Model counts a pulse one edge after it shows; let the last one land
    repeat (2) @(posedge i_clk);
    cmp({24'h0, cycles}, 32'h3, "card cycles");
    wr(`IOWD_IDX_MAPEN, 8'h80);
    io(16'h0110, 1'b0, 1'b0, 16'h0, 1'b0, 1'b0);
    $display("test window done");
  endtask

  // Other window's bits set inverted to catch crossed fields
  task automatic t_modes();
    logic s, au, ts;
    wr(`IOWD_IDX_MAPEN, 8'hC0);
    for (int i = 0; i < 16; i++)
    begin
      {ts, au, s} = 3'(i);
      card_wide <= i[3];
      wr(`IOWD_IDX_CTRL, {~ts, 1'b0, ~au, ~s, ts, 1'b0, au, s});
      io(16'h0150, 1'b1, 1'b0, 16'h1150, au ? card_wide : s, ts);
      wr(`IOWD_IDX_CTRL, {ts, 1'b0, au, s, ~ts, 1'b0, ~au, ~s});
      io(16'h0350, 1'b1, 1'b1, 16'h0370, au ? card_wide : s, ts);
    end
    $display("test modes done");
  endtask

  initial
  begin
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_reset();
    t_regs();
    t_window();
    t_modes();
    conclude();
  end
endmodule
